// File: hdl/rsq_params.svh
// Purpose : constants for the reset and initialization sequencer
// Assumes : 20 MHz clk, byte-wide register port
// Notes   : offsets are the register addresses seen on the plain port
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH

// ************************************************************
// register addresses
// ************************************************************
`define RSQ_ADDR_PORT_A      8'h00
`define RSQ_ADDR_PORT_B      8'h01
`define RSQ_ADDR_FLAG_CLR    8'h10
`define RSQ_ADDR_INT_FLAGS   8'h11
`define RSQ_ADDR_INT_ENABLE  8'h12
`define RSQ_ADDR_PROC_STAT   8'h13
`define RSQ_ADDR_MODE_CTRL   8'h14
`define RSQ_ADDR_SER_CTRL    8'h15
`define RSQ_ADDR_SER_STAT    8'h16

// ************************************************************
// reset values and field positions
// ************************************************************
`define RSQ_RST_MODE_CTRL    8'hE0
`define RSQ_RST_INT_ENABLE   8'h00
`define RSQ_RST_INT_FLAGS    8'h00
`define RSQ_RST_SER_CTRL     8'h00
`define RSQ_RST_SER_STAT     8'h40
`define RSQ_RST_PORT         8'hFF
`define RSQ_FLAG_CLR_MASK    8'h0F
`define RSQ_SER_STAT_WR_MASK 8'h30
`define RSQ_FLAG_CLR_READ    8'hFF
`define RSQ_UNMAPPED_READ    8'h00
`define RSQ_IMASK_BIT        2
`define RSQ_BUSY_BIT         7

// ************************************************************
// timing counts
// ************************************************************
`define RSQ_SEQ_CYCLES       16
`define RSQ_MIN_HOLD_CYCLES  8

`endif

// File: hdl/rsq_pkg.sv
// Purpose : types shared by the sequencer files
// Assumes : nothing beyond SystemVerilog
// Notes   : constants live in rsq_params.svh
package rsq_pkg;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [1:0]
    {
        RSQ_HELD,
        RSQ_INIT,
        RSQ_RUN
    } rsq_state_t;

    // ************************************************************
    // snapshot of the reset-controlled registers
    // ************************************************************
    typedef struct packed
    {
        logic [7:0] mode_control;
        logic [7:0] interrupt_enable;
        logic [7:0] interrupt_flags;
        logic [7:0] serial_control;
        logic [7:0] serial_status;
        logic [7:0] port_a_latch;
        logic [7:0] port_b_latch;
    } rsq_regs_t;

endpackage : rsq_pkg

// File: hdl/rsq_pin_sync.sv
// Purpose : bring the asynchronous init pin into the clk domain
// Assumes : pin may change at any time
// Notes   : the output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module rsq_pin_sync
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output var  logic level_out
);

    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    // ************************************************************
    // three stage shift, stage 0 feeds only stage 1
    // ************************************************************
    always_comb
    begin
        stage_next = {stage_reg[1:0], pin_in};
        level_next = level_reg;
        // a single-cycle glitch past stage 1 is filtered here
        if (stage_reg[1] == stage_reg[2])
        begin
            level_next = stage_reg[2];
        end
    end

    // reset assumes the line is low, as it is during power-up
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_reg <= 3'h0;
            level_reg <= 1'b0;
        end
        else
        begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;

endmodule : rsq_pin_sync

`default_nettype wire

// File: hdl/rsq_init_seq.sv
// Purpose : reset and initialization sequencer of the one-chip controller
// Assumes : 20 MHz clk, chip_init_line_n asynchronous from an external circuit
// Notes   : registers reached over a plain address/strobe port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "rsq_params.svh"

module rsq_init_seq
#(
    parameter int SEQ_CYCLES = `RSQ_SEQ_CYCLES
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              chip_init_line_n,
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output var  logic [7:0]        rdata,
    input  wire logic [7:0]        flag_set,
    input  wire logic [7:0]        ser_stat_hw,
    output var  logic [7:0]        port_a,
    output var  logic [7:0]        port_b,
    output var  logic              imask,
    output var  logic              seq_busy,
    output var  rsq_pkg::rsq_regs_t regs
);

    localparam int CNT_W = $clog2(SEQ_CYCLES + 1);

    // ************************************************************
    // declarations
    // ************************************************************
    logic                line_level;
    logic                line_prev_reg;
    logic                line_prev_next;
    logic                line_rise;
    rsq_pkg::rsq_state_t state_reg;
    rsq_pkg::rsq_state_t state_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic [7:0]          mode_reg;
    logic [7:0]          mode_next;
    logic [7:0]          ier_reg;
    logic [7:0]          ier_next;
    logic [7:0]          flags_reg;
    logic [7:0]          flags_next;
    logic [7:0]          sctl_reg;
    logic [7:0]          sctl_next;
    logic [7:0]          ssts_reg;
    logic [7:0]          ssts_next;
    logic [7:0]          pa_reg;
    logic [7:0]          pa_next;
    logic [7:0]          pb_reg;
    logic [7:0]          pb_next;
    logic                imask_reg;
    logic                imask_next;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;
    logic                wr_ok;

    // ************************************************************
    // init pin synchroniser
    // ************************************************************
    rsq_pin_sync u_line_sync
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (chip_init_line_n),
        .level_out (line_level)
    );

    // rising edge of the filtered line marks reset release
    always_comb
    begin
        line_prev_next = line_level;
        line_rise      = line_level & ~line_prev_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_prev_reg <= 1'b0;
        end
        else
        begin
            line_prev_reg <= line_prev_next;
        end
    end

    // ************************************************************
    // sequencer state
    // ************************************************************
    // the line is not timed here: a too-short hold is the source's fault
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            rsq_pkg::RSQ_HELD:
            begin
                cnt_next = '0;
                if (line_rise)                                   // wait for the rise
                begin
                    state_next = rsq_pkg::RSQ_INIT;
                end
            end
            rsq_pkg::RSQ_INIT:
            begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg == CNT_W'(SEQ_CYCLES - 1))          // 16 cycles
                begin
                    state_next = rsq_pkg::RSQ_RUN;
                    cnt_next   = '0;
                end
            end
            rsq_pkg::RSQ_RUN:
            begin
                cnt_next = '0;
            end
        endcase
        // line dropping again restarts from the held state
        if (!line_level)
        begin
            state_next = rsq_pkg::RSQ_HELD;
            cnt_next   = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= rsq_pkg::RSQ_HELD;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // software writes only land once the sequence is done
    assign wr_ok = wr_stb && (state_reg == rsq_pkg::RSQ_RUN);

    // ************************************************************
    // reset-controlled registers
    // ************************************************************
    // ram and cpu working registers are outside this block and stay random
    always_comb
    begin
        mode_next  = mode_reg;
        ier_next   = ier_reg;
        flags_next = flags_reg;
        sctl_next  = sctl_reg;
        ssts_next  = ssts_reg;
        pa_next    = pa_reg;
        pb_next    = pb_reg;
        imask_next = imask_reg;
        unique case (state_reg)
            rsq_pkg::RSQ_HELD:
            begin
                // everything pinned at reset values while the line is low
                mode_next  = `RSQ_RST_MODE_CTRL;
                ier_next   = `RSQ_RST_INT_ENABLE;
                flags_next = `RSQ_RST_INT_FLAGS;
                sctl_next  = `RSQ_RST_SER_CTRL;
                ssts_next  = `RSQ_RST_SER_STAT;
                pa_next    = `RSQ_RST_PORT;
                pb_next    = `RSQ_RST_PORT;
                imask_next = 1'b1;
                if (line_rise)
                begin
                    imask_next = 1'b1;
                    pa_next    = `RSQ_RST_PORT;
                    pb_next    = `RSQ_RST_PORT;
                end
            end
            rsq_pkg::RSQ_INIT:
            begin
                // mode bits 7:5 set, counter mode 00 and enables cleared
                mode_next  = `RSQ_RST_MODE_CTRL;
                ier_next   = `RSQ_RST_INT_ENABLE;
                flags_next = `RSQ_RST_INT_FLAGS;
                sctl_next  = `RSQ_RST_SER_CTRL;
                ssts_next  = `RSQ_RST_SER_STAT;
                imask_next = 1'b1;
            end
            rsq_pkg::RSQ_RUN:
            begin
                // serial status: bits 4,5 are software, the rest follow hardware
                ssts_next = (ssts_reg & `RSQ_SER_STAT_WR_MASK)
                          | (ser_stat_hw & ~`RSQ_SER_STAT_WR_MASK);
                if (wr_ok)
                begin
                    unique case (addr)
                        `RSQ_ADDR_PORT_A:     pa_next   = wdata;
                        `RSQ_ADDR_PORT_B:     pb_next   = wdata;
                        `RSQ_ADDR_MODE_CTRL:  mode_next = wdata;
                        `RSQ_ADDR_INT_ENABLE: ier_next  = wdata;
                        `RSQ_ADDR_SER_CTRL:   sctl_next = wdata;
                        `RSQ_ADDR_SER_STAT:
                        begin
                            ssts_next = (ssts_next & ~`RSQ_SER_STAT_WR_MASK)
                                      | (wdata & `RSQ_SER_STAT_WR_MASK);
                        end
                        `RSQ_ADDR_FLAG_CLR:
                        begin
                            // a zero in bits 3:0 clears that flag
                            flags_next = flags_reg & ~(~wdata & `RSQ_FLAG_CLR_MASK);
                        end
                        `RSQ_ADDR_PROC_STAT:
                        begin
                            // program clears the mask when set-up is done
                            imask_next = wdata[`RSQ_IMASK_BIT];
                        end
                        default:
                        begin
                            mode_next = mode_reg;
                        end
                    endcase
                end
                // a flag event in the clearing cycle still lands
                flags_next = flags_next | flag_set;
            end
        endcase
        // a fall of the line forces reset values at once
        if (!line_level)
        begin
            mode_next  = `RSQ_RST_MODE_CTRL;
            ier_next   = `RSQ_RST_INT_ENABLE;
            flags_next = `RSQ_RST_INT_FLAGS;
            sctl_next  = `RSQ_RST_SER_CTRL;
            ssts_next  = `RSQ_RST_SER_STAT;
            pa_next    = `RSQ_RST_PORT;
            pb_next    = `RSQ_RST_PORT;
            imask_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg  <= `RSQ_RST_MODE_CTRL;
            ier_reg   <= `RSQ_RST_INT_ENABLE;
            flags_reg <= `RSQ_RST_INT_FLAGS;
            sctl_reg  <= `RSQ_RST_SER_CTRL;
            ssts_reg  <= `RSQ_RST_SER_STAT;
            pa_reg    <= `RSQ_RST_PORT;
            pb_reg    <= `RSQ_RST_PORT;
            imask_reg <= 1'b1;
        end
        else
        begin
            mode_reg  <= mode_next;
            ier_reg   <= ier_next;
            flags_reg <= flags_next;
            sctl_reg  <= sctl_next;
            ssts_reg  <= ssts_next;
            pa_reg    <= pa_next;
            pb_reg    <= pb_next;
            imask_reg <= imask_next;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // data register holds only for the cycle after the strobe
    always_comb
    begin
        rdata_next = `RSQ_UNMAPPED_READ;
        if (rd_stb)
        begin
            unique case (addr)
                `RSQ_ADDR_PORT_A:     rdata_next = pa_reg;
                `RSQ_ADDR_PORT_B:     rdata_next = pb_reg;
                `RSQ_ADDR_FLAG_CLR:   rdata_next = `RSQ_FLAG_CLR_READ;
                `RSQ_ADDR_INT_FLAGS:  rdata_next = flags_reg;
                `RSQ_ADDR_INT_ENABLE: rdata_next = ier_reg;
                `RSQ_ADDR_MODE_CTRL:  rdata_next = mode_reg;
                `RSQ_ADDR_SER_CTRL:   rdata_next = sctl_reg;
                `RSQ_ADDR_SER_STAT:   rdata_next = ssts_reg;
                `RSQ_ADDR_PROC_STAT:
                begin
                    rdata_next                 = 8'h00;
                    rdata_next[`RSQ_IMASK_BIT] = imask_reg;
                    rdata_next[`RSQ_BUSY_BIT]  = (state_reg != rsq_pkg::RSQ_RUN);
                end
                default:              rdata_next = `RSQ_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= `RSQ_UNMAPPED_READ;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // outputs, all from flip-flops except seq_busy, decoded from state_reg
    // ************************************************************
    assign rdata                  = rdata_reg;
    assign port_a                 = pa_reg;
    assign port_b                 = pb_reg;
    assign imask                  = imask_reg;
    assign seq_busy               = (state_reg != rsq_pkg::RSQ_RUN);
    assign regs.mode_control      = mode_reg;
    assign regs.interrupt_enable  = ier_reg;
    assign regs.interrupt_flags   = flags_reg;
    assign regs.serial_control    = sctl_reg;
    assign regs.serial_status     = ssts_reg;
    assign regs.port_a_latch      = pa_reg;
    assign regs.port_b_latch      = pb_reg;

endmodule : rsq_init_seq

`default_nettype wire

// File: testbench/rsq_reset_src.sv
// Purpose : model of the external power-on circuit that drives the init line
// Assumes : hold_req comes from the bench, high asks for the line to be held low
// Notes   : release is delayed until the minimum low time has elapsed
`timescale 1ns/1ps
`default_nettype none

module rsq_reset_src
#(
    parameter int HOLD_CYCLES = 8
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic hold_req,
    output var  logic chip_init_line_n
);
    // ************************************************************
    // low-time counter
    // ************************************************************
    logic [7:0] hold_cnt_reg;
    logic [7:0] hold_cnt_next;
    logic       line_next;

    // a short request is stretched, so the device never sees a runt low pulse
    always_comb
    begin
        hold_cnt_next = hold_cnt_reg;
        if (hold_req)
            hold_cnt_next = 8'h00;
        else if (hold_cnt_reg < 8'(HOLD_CYCLES))
            hold_cnt_next = hold_cnt_reg + 8'h01;
        line_next = !hold_req && (hold_cnt_reg >= 8'(HOLD_CYCLES));
    end

    // line starts low so power-up always begins with a held device
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt_reg     <= 8'h00;
            chip_init_line_n <= 1'b0;
        end
        else
        begin
            hold_cnt_reg     <= hold_cnt_next;
            chip_init_line_n <= line_next;
        end
    end
endmodule : rsq_reset_src

`default_nettype wire

// File: testbench/rsq_init_seq_checker.sv
// Purpose : port-level properties of the init sequencer
// Assumes : SEQ_CYCLES at its default of 16, three-flop pin filter
// Notes   : cycle counts assume the filter settles on the fourth sampled edge, no jitter modelled
`timescale 1ns/1ps
`default_nettype none
`include "rsq_params.svh"

module rsq_init_seq_checker
#(
    parameter int SEQ_CYCLES = 16
)
(
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               chip_init_line_n,
    input wire logic [7:0]         addr,
    input wire logic               wr_stb,
    input wire logic               rd_stb,
    input wire logic [7:0]         rdata,
    input wire logic [7:0]         port_a,
    input wire logic [7:0]         port_b,
    input wire logic               imask,
    input wire logic               seq_busy,
    input wire rsq_pkg::rsq_regs_t regs
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // sequences and properties
    // ************************************************************
    // rise seen, then line kept high long enough to be past the filter
    sequence s_rise_hold;
        $rose(chip_init_line_n) ##1 chip_init_line_n[*8];
    endsequence
    sequence s_line_low;
        (!chip_init_line_n)[*5];
    endsequence

    property p_held_outputs;
        s_line_low |=> seq_busy && port_a == 8'hFF && port_b == 8'hFF && imask;
    endproperty
    a_held_outputs: assert property (p_held_outputs) else $error("outputs left reset state while line low");
    property p_held_mode;
        s_line_low |=> regs.mode_control == `RSQ_RST_MODE_CTRL && regs.interrupt_enable == 8'h00;
    endproperty
    a_held_mode: assert property (p_held_mode) else $error("mode or enable not at reset value");
    property p_held_serial;
        s_line_low |=> regs.interrupt_flags == 8'h00 && regs.serial_control == 8'h00
            && regs.serial_status == `RSQ_RST_SER_STAT;
    endproperty
    a_held_serial: assert property (p_held_serial) else $error("flags or serial regs not at reset value");
    property p_seq_length;
        s_rise_hold |-> seq_busy[*8] ##1 seq_busy[*5] ##1 !seq_busy;
    endproperty
    a_seq_length: assert property (p_seq_length) else $error("init sequence length wrong");
    property p_mask_on_rise;
        s_rise_hold |-> imask;
    endproperty
    a_mask_on_rise: assert property (p_mask_on_rise) else $error("mask not set after release");
    property p_run_entry;
        $fell(seq_busy) |-> imask && port_a == 8'hFF && port_b == 8'hFF
            && regs.mode_control == `RSQ_RST_MODE_CTRL && regs.interrupt_enable == 8'h00;
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("values wrong at end of sequence");
    property p_no_write_busy;
        seq_busy && wr_stb && addr == `RSQ_ADDR_MODE_CTRL |=> regs.mode_control == `RSQ_RST_MODE_CTRL;
    endproperty
    a_no_write_busy: assert property (p_no_write_busy) else $error("write accepted during sequence");
    property p_rdata_idle;
        !$past(rd_stb) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule : rsq_init_seq_checker

bind rsq_init_seq rsq_init_seq_checker #(.SEQ_CYCLES(SEQ_CYCLES)) u_chk
(
    .clk(clk), .rst_n(rst_n), .chip_init_line_n(chip_init_line_n), .addr(addr), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .port_a(port_a), .port_b(port_b), .imask(imask),
    .seq_busy(seq_busy), .regs(regs)
);

`default_nettype wire

// File: testbench/tb.sv
// Purpose : self-checking bench for the init sequencer
// Assumes : 20 MHz clock, partner model drives the init line
// Notes   : register-snapshot reset expectations come from RST_REGS, read-back and other values are literals in the bench
`timescale 1ns/1ps
`default_nettype none
`include "rsq_params.svh"

module tb;
    logic               clk, rst_n, hold_req, line_n, wr_stb, rd_stb, imask, seq_busy;
    logic [7:0]         addr, wdata, rdata, flag_set, ser_stat_hw, port_a, port_b;
    rsq_pkg::rsq_regs_t regs;
    int                 miscompares, n_compared, cyc;
    localparam logic [55:0] RST_REGS = {8'hE0, 8'h00, 8'h00, 8'h00, 8'h40, 8'hFF, 8'hFF};

    rsq_reset_src #(.HOLD_CYCLES(`RSQ_MIN_HOLD_CYCLES)) u_src
        (.clk(clk), .rst_n(rst_n), .hold_req(hold_req), .chip_init_line_n(line_n));
    rsq_init_seq DUT
    (
        .clk(clk), .rst_n(rst_n), .chip_init_line_n(line_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .flag_set(flag_set),
        .ser_stat_hw(ser_stat_hw), .port_a(port_a), .port_b(port_b), .imask(imask),
        .seq_busy(seq_busy), .regs(regs)
    );

    // ************************************************************
    // clock, timeout and helpers
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [55:0] e, input logic [55:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", name, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    // data stand in the cycle after the strobe edge only
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk($sformatf("read %h", a), {48'h0, e}, {48'h0, rdata});
    endtask : rd

    // bounded wait for the sequence to finish
    task automatic wait_run;
        int n;
        n = 0;
        while (seq_busy !== 1'b0 && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        #1;
        chk("busy", 56'h0, {55'h0, seq_busy});
    endtask : wait_run

    task automatic chk_reset_state;
        chk("regs", RST_REGS, regs);
        chk("imask", 56'h1, {55'h0, imask});
    endtask : chk_reset_state

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        {rst_n, wr_stb, rd_stb, addr, wdata, flag_set} = '0;
        hold_req    = 1'b1;
        ser_stat_hw = 8'h40;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        wr(`RSQ_ADDR_MODE_CTRL, 8'h00);
        rd(`RSQ_ADDR_MODE_CTRL, 8'hE0);
        chk_reset_state();
        chk("busy held", 56'h1, {55'h0, seq_busy});
        @(posedge clk) hold_req <= 1'b0;
        wait_run();
        chk_reset_state();
        rd(`RSQ_ADDR_PORT_A, 8'hFF);
        rd(`RSQ_ADDR_PORT_B, 8'hFF);
        rd(`RSQ_ADDR_FLAG_CLR, 8'hFF);
        rd(`RSQ_ADDR_INT_FLAGS, 8'h00);
        rd(`RSQ_ADDR_INT_ENABLE, 8'h00);
        rd(`RSQ_ADDR_MODE_CTRL, 8'hE0);
        rd(`RSQ_ADDR_SER_CTRL, 8'h00);
        rd(`RSQ_ADDR_SER_STAT, 8'h40);
        rd(8'h20, 8'h00);
        // program sets its own values and drops the mask
        wr(`RSQ_ADDR_PORT_A, 8'h5A);
        wr(`RSQ_ADDR_PORT_B, 8'hA5);
        wr(`RSQ_ADDR_MODE_CTRL, 8'h03);
        wr(`RSQ_ADDR_INT_ENABLE, 8'h0F);
        wr(`RSQ_ADDR_SER_CTRL, 8'h81);
        wr(`RSQ_ADDR_SER_STAT, 8'h30);
        wr(`RSQ_ADDR_PROC_STAT, 8'h00);
        @(posedge clk) flag_set <= 8'h03;
        @(posedge clk) flag_set <= 8'h00;
        wr(`RSQ_ADDR_INT_FLAGS, 8'hFF);
        rd(`RSQ_ADDR_INT_FLAGS, 8'h03);
        wr(`RSQ_ADDR_FLAG_CLR, 8'hFC);
        rd(`RSQ_ADDR_INT_FLAGS, 8'h00);
        rd(`RSQ_ADDR_MODE_CTRL, 8'h03);
        rd(`RSQ_ADDR_SER_STAT, 8'h70);
        // hardware-owned status bits follow their source, software bits 5:4 are kept
        @(posedge clk) ser_stat_hw <= 8'hC5;
        rd(`RSQ_ADDR_SER_STAT, 8'hF5);
        @(posedge clk) ser_stat_hw <= 8'h40;
        chk("port a", 56'h5A, {48'h0, port_a});
        chk("imask clear", 56'h0, {55'h0, imask});
        @(posedge clk) flag_set <= 8'h01;
        @(posedge clk) flag_set <= 8'h00;
        // a second init pulse must restore every controlled value
        hold_req <= 1'b1;
        @(posedge clk) hold_req <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk_reset_state();
        wait_run();
        chk_reset_state();
        rd(`RSQ_ADDR_PORT_B, 8'hFF);
        final_report();
    end
endmodule : tb

`default_nettype wire
